//--- rtl/dswi_flux_edge.sv
// Rising-difference detector for a differential flux pair
`timescale 1ns/1ns
`default_nettype none
module dswi_flux_edge (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pos,
  input wire logic neg,
  output logic edge_seen
);
  typedef struct packed {
    logic prev;
    logic edge_seen;
  } dswi_edge_t;
  dswi_edge_t s, next_s;
  // Positive leg above negative leg counts as one reversal when newly true
  always_comb begin
    next_s.prev = pos & ~neg;
    next_s.edge_seen = (pos & ~neg) & ~s.prev;
  end
  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '{prev: 1'b0, edge_seen: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign edge_seen = s.edge_seen;
endmodule : dswi_flux_edge
`default_nettype wire

//--- rtl/dswi_pkg.sv
// Package of constants and types for the disc seek and write interface
package dswi_pkg;
  // Clock rate and derived timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned REV_PERIOD_US = 16_670;
  localparam int unsigned REV_PERIOD_CYC = REV_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MARK_PULSE_NS = 1_000;
  localparam int unsigned MARK_PULSE_CYC = (MARK_PULSE_NS * 25 + 999) / 1_000;
  localparam int unsigned SETTLE_NS = 2_000;
  localparam int unsigned SETTLE_CYC = SETTLE_NS / 40;
  localparam int unsigned WDATA_TIMEOUT_NS = 10_000;
  localparam int unsigned WDATA_TIMEOUT_CYC = WDATA_TIMEOUT_NS / 40;
  localparam int unsigned SPEED_TOL_PCT = 2;
  localparam int unsigned CYL_W = 12;
  localparam logic [11:0] MAX_CYL = 12'h0_3FF;
  localparam int unsigned HEAD_W = 4;
  localparam logic [3:0] HEAD_COUNT = 4'h8;
  localparam logic DIR_IN_LEVEL = 1'b0;
  // Register map over AXI4-Lite
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_CYL = 8'h14;
  // Control bit positions
  localparam int unsigned CTRL_PWR_OK = 0;
  localparam int unsigned CTRL_WPROT = 1;
  localparam int unsigned CTRL_HEAD_OPEN = 2;
  localparam int unsigned CTRL_HEAD_SHORT = 3;
  localparam int unsigned CTRL_BAD_CURR = 4;
  localparam int unsigned CTRL_OFF_TRACK = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // Interrupt event positions
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_SETTLED = 1;
  localparam int unsigned EV_REV = 2;
  localparam int unsigned EV_SPEED = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Seek machine states, one-hot
  typedef enum logic [3:0] {
    DSWI_RECAL = 4'b0001,
    DSWI_IDLE = 4'b0010,
    DSWI_SETTLE = 4'b0100,
    DSWI_LOCKED = 4'b1000
  } dswi_seek_t;
endpackage : dswi_pkg

//--- rtl/dswi_pulse_timer.sv
// Free-running period timer that emits a low-going marker each period
`timescale 1ns/1ns
`default_nettype none
module dswi_pulse_timer
  import dswi_pkg::*;
#(
  parameter int unsigned PERIOD = REV_PERIOD_CYC,
  parameter int unsigned WIDTH = MARK_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic tick,
  output logic marker_n
);
  typedef struct packed {
    logic [31:0] count;
    logic tick;
    logic marker_n;
  } dswi_tmr_t;
  dswi_tmr_t s, next_s;
  // Counter, tick at wrap, marker low for WIDTH cycles
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.count = 32'h0000_0000;
      next_s.marker_n = 1'b1;
    end else if (s.count == PERIOD - 1) begin
      next_s.count = 32'h0000_0000;
      next_s.tick = 1'b1;
      next_s.marker_n = 1'b0;
    end else begin
      next_s.count = s.count + 32'h0000_0001;
      if (s.count == WIDTH - 1) begin
        next_s.marker_n = 1'b1;
      end
    end
  end
  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '{count: 32'h0000_0000, tick: 1'b0, marker_n: 1'b1};
    end else begin
      s <= next_s;
    end
  end
  assign tick = s.tick;
  assign marker_n = s.marker_n;
endmodule : dswi_pulse_timer
`default_nettype wire

//--- rtl/dswi_top.sv
// Drive-side seek, write and fault logic with an AXI4-Lite register slave
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dswi_top
  import dswi_pkg::*;
#(
  parameter int unsigned REV_CYC = REV_PERIOD_CYC,
  parameter logic DIR_IN = DIR_IN_LEVEL
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic drive_select_n,
  input wire logic step_n,
  input wire logic direction_n,
  input wire logic [3:0] head_select_code_n,
  input wire logic write_enable_gate_n,
  input wire logic write_flux_pos,
  input wire logic write_flux_neg,
  input wire logic head_flux_in,
  input wire logic spindle_tick,
  output logic seek_settled_n,
  output logic at_outer_cylinder_n,
  output logic ready_n,
  output logic revolution_marker_n,
  output logic write_unsafe_fault_n,
  output logic read_flux_pos,
  output logic read_flux_neg,
  output logic head_flux_out,
  output logic preamp_write_mode,
  output logic unsafe_sense_current,
  output logic [3:0] head_active,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Whole state of the block except the timer and flux edge detectors
  typedef struct packed {
    dswi_seek_t seek;
    logic [CYL_W-1:0] cyl;           // Current cylinder
    logic [15:0] settle_cnt;         // Settle delay counter
    logic [15:0] wdata_cnt;          // Cycles since last write transition
    logic [31:0] rev_cnt;            // Cycles since last spindle tick
    logic step_prev;                 // Step line history for edge detect
    logic sel_prev;                  // Select history for deselect edge
    logic fault;                     // Latched write fault
    logic locked;                    // Speed-loss lockout
    logic settled;
    logic outer;
    logic ready;
    logic wmode;
    logic unsafe;
    logic flux_out;
    logic rd_pos;
    logic [3:0] head;
    logic [5:0] ctrl;                // Software-driven condition inputs
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_en;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dswi_state_t;
  dswi_state_t s, next_s;

  logic rev_tick;      // Revolution period tick
  logic marker_n;      // Revolution marker from timer
  logic wr_edge;       // Write-data reversal seen
  logic rd_edge;       // Read-back reversal from head

  // Revolution marker timing, runs only while power is good and no speed lockout stands
  dswi_pulse_timer #(.PERIOD(REV_CYC), .WIDTH(MARK_PULSE_CYC)) u_rev (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(s.ctrl[CTRL_PWR_OK] & ~s.locked),
    .tick(rev_tick),
    .marker_n(marker_n)
  );
  // Write data differential pair
  dswi_flux_edge u_wedge (
    .sys_clk(sys_clk),
    .rst(rst),
    .pos(write_flux_pos),
    .neg(write_flux_neg),
    .edge_seen(wr_edge)
  );
  // Head read-back pair, single ended from the preamp
  dswi_flux_edge u_redge (
    .sys_clk(sys_clk),
    .rst(rst),
    .pos(head_flux_in),
    .neg(1'b0),
    .edge_seen(rd_edge)
  );

  // Next-state logic for seek, fault, flux and register slave
  always_comb begin
    logic selected;
    logic writing;
    logic step_edge;
    logic fault_cause;
    logic speed_bad;
    logic wr_fire;
    logic rd_fire;
    logic [EV_W-1:0] ev_set;
    logic [7:0] wa;
    selected = 1'b0;
    writing = 1'b0;
    step_edge = 1'b0;
    fault_cause = 1'b0;
    speed_bad = 1'b0;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    ev_set = '0;
    wa = 8'h00;
    next_s = s;
    selected = ~drive_select_n;
    next_s.sel_prev = selected;
    next_s.step_prev = ~step_n;
    // Commands are refused while a fault or lockout stands
    step_edge = selected & ~step_n & ~s.step_prev & ~s.fault & ~s.locked;
    writing = selected & ~write_enable_gate_n & ~s.fault & ~s.locked;

    // Spindle speed watch: tick spacing outside the tolerance band
    next_s.rev_cnt = spindle_tick ? 32'h0000_0000 : s.rev_cnt + 32'h0000_0001;
    if (s.ctrl[CTRL_PWR_OK] && s.seek != DSWI_RECAL) begin
      if (s.rev_cnt > REV_CYC + REV_CYC * SPEED_TOL_PCT / 100) begin
        speed_bad = 1'b1;
      end
      if (spindle_tick && s.rev_cnt < REV_CYC - REV_CYC * SPEED_TOL_PCT / 100) begin
        speed_bad = 1'b1;
      end
    end
    if (speed_bad && !s.locked) begin
      next_s.locked = 1'b1;
      ev_set[EV_SPEED] = 1'b1;
    end

    // Seek machine
    unique case (s.seek)
      DSWI_RECAL: begin
        // Recalibrate to cylinder zero once power is good
        next_s.cyl = '0;
        if (s.ctrl[CTRL_PWR_OK] && spindle_tick) begin
          next_s.seek = DSWI_SETTLE;
          next_s.settle_cnt = '0;
        end
      end
      DSWI_IDLE: begin
        if (step_edge) begin
          // Move one track, clamped at the ends
          if ((direction_n == DIR_IN) && s.cyl != MAX_CYL) begin
            next_s.cyl = s.cyl + 12'h001;
          end else if ((direction_n != DIR_IN) && s.cyl != '0) begin
            next_s.cyl = s.cyl - 12'h001;
          end
          next_s.seek = DSWI_SETTLE;
          next_s.settle_cnt = '0;
        end
      end
      DSWI_SETTLE: begin
        // A further step restarts settling
        if (step_edge) begin
          if ((direction_n == DIR_IN) && s.cyl != MAX_CYL) begin
            next_s.cyl = s.cyl + 12'h001;
          end else if ((direction_n != DIR_IN) && s.cyl != '0) begin
            next_s.cyl = s.cyl - 12'h001;
          end
          next_s.settle_cnt = '0;
        end else if (s.settle_cnt == 16'(SETTLE_CYC - 1)) begin
          next_s.seek = DSWI_IDLE;
          ev_set[EV_SETTLED] = 1'b1;
        end else begin
          next_s.settle_cnt = s.settle_cnt + 16'h0001;
        end
      end
      DSWI_LOCKED: begin
        // Actuator locked until power cycle
        next_s.seek = DSWI_LOCKED;
      end
    endcase
    if (next_s.locked) begin
      next_s.seek = DSWI_LOCKED;
    end
    next_s.settled = (next_s.seek == DSWI_IDLE);
    next_s.outer = (next_s.cyl == '0);
    next_s.ready = (next_s.seek != DSWI_RECAL) & ~next_s.locked
                 & s.ctrl[CTRL_PWR_OK];

    // Head select, lines active low, all high gives head zero
    next_s.head = ~head_select_code_n;

    // Write path and unsafe sense
    next_s.wmode = writing;
    wr_fire = writing & wr_edge;
    if (writing && !wr_edge) begin
      next_s.wdata_cnt = (s.wdata_cnt == 16'hFFFF) ? s.wdata_cnt : s.wdata_cnt + 16'h0001;
    end else begin
      next_s.wdata_cnt = '0;
    end
    next_s.unsafe = writing & (s.wdata_cnt >= 16'(WDATA_TIMEOUT_CYC));
    if (wr_fire) begin
      next_s.flux_out = ~s.flux_out;
    end
    // Read path, one reversal shown as a one-cycle rise
    rd_fire = ~writing & rd_edge;
    next_s.rd_pos = rd_fire;

    // Fault detection while writing
    if (writing) begin
      fault_cause = s.ctrl[CTRL_HEAD_OPEN] | s.ctrl[CTRL_HEAD_SHORT]
                  | s.ctrl[CTRL_BAD_CURR] | s.ctrl[CTRL_OFF_TRACK]
                  | (s.head >= HEAD_COUNT) | speed_bad;
      fault_cause = fault_cause | ~s.settled | ~s.ready
                  | s.ctrl[CTRL_WPROT] | s.unsafe;
    end
    if (fault_cause) begin
      next_s.fault = 1'b1;
      ev_set[EV_FAULT] = 1'b1;
    end else if (s.fault && s.sel_prev && !selected) begin
      // Re-examine conditions on deselect
      next_s.fault = s.ctrl[CTRL_HEAD_OPEN] | s.ctrl[CTRL_HEAD_SHORT]
                   | s.ctrl[CTRL_BAD_CURR] | s.ctrl[CTRL_OFF_TRACK];
    end
    ev_set[EV_REV] = rev_tick;

    // AXI4-Lite write channel, address and data in either order
    next_s.ev_stat = s.ev_stat;
    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wa = {s.aw_addr[7:2], 2'b00};
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (wa == ADDR_CTRL) begin
        if (s.w_strb[0]) next_s.ctrl = s.w_data[5:0];
      end else if (wa == ADDR_IRQ_EN) begin
        if (s.w_strb[0]) next_s.ev_en = s.w_data[EV_W-1:0];
      end else if (wa == ADDR_IRQ_CLR) begin
        // Clear wins only where no new event arrives
        if (s.w_strb[0]) next_s.ev_stat = s.ev_stat & ~s.w_data[EV_W-1:0];
      end else if (wa != ADDR_STATUS && wa != ADDR_IRQ_STAT && wa != ADDR_CYL) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.ev_stat = next_s.ev_stat | ev_set;
    next_s.irq = |(next_s.ev_stat & next_s.ev_en);

    // AXI4-Lite read channel
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ADDR_STATUS: next_s.rdata = {24'h00_0000, s.head, s.fault, s.locked,
                                     s.ready, s.settled};
        ADDR_IRQ_STAT: next_s.rdata = {28'h000_0000, s.ev_stat};
        ADDR_IRQ_EN: next_s.rdata = {28'h000_0000, s.ev_en};
        ADDR_IRQ_CLR: next_s.rdata = 32'h0000_0000;
        ADDR_CTRL: next_s.rdata = {26'h000_0000, s.ctrl};
        ADDR_CYL: next_s.rdata = {20'h0_0000, s.cyl};
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.seek <= DSWI_RECAL;
      s.ctrl <= CTRL_RESET;
      s.outer <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops, active-low lines inverted at the register
  assign seek_settled_n = ~s.settled;
  assign at_outer_cylinder_n = ~s.outer;
  assign ready_n = ~s.ready;
  assign revolution_marker_n = marker_n;
  assign write_unsafe_fault_n = ~s.fault;
  assign read_flux_pos = s.rd_pos;
  assign read_flux_neg = ~s.rd_pos;
  assign head_flux_out = s.flux_out;
  assign preamp_write_mode = s.wmode;
  assign unsafe_sense_current = s.unsafe;
  assign head_active = s.head;
  assign irq = s.irq;
  assign s_axi_awready = ~s.aw_got;
  assign s_axi_wready = ~s.w_got;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
endmodule : dswi_top
`default_nettype wire

//--- testbench/dswi_ctrl_model.sv
// Behavioural disc controller driving step, head and write lines
`timescale 1ns/1ns
`default_nettype none
module dswi_ctrl_model (
  input wire logic sys_clk,
  input wire logic seek_settled_n,
  output logic drive_select_n,
  output logic step_n,
  output logic direction_n,
  output logic [3:0] head_select_code_n,
  output logic write_enable_gate_n,
  output logic write_flux_pos,
  output logic write_flux_neg
);
  // Idle levels: selected, no step, head 0, reading, no reversal
  initial begin
    drive_select_n = 1'b0;
    step_n = 1'b1;
    direction_n = 1'b1;
    head_select_code_n = 4'hF;
    write_enable_gate_n = 1'b1;
    write_flux_pos = 1'b0;
    write_flux_neg = 1'b1;
  end
  // One low pulse per track; gap sets prompt or slow spacing
  task automatic step(input logic dir, input int gap);
    @(posedge sys_clk);
    direction_n <= dir;
    @(posedge sys_clk);
    step_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    step_n <= 1'b1;
    repeat (gap) @(posedge sys_clk);
  endtask : step
  // Binary head code, all lines inactive selects head 0
  task automatic head(input logic [3:0] h);
    @(posedge sys_clk);
    head_select_code_n <= ~h;
  endtask : head
  // Opening the gate waits for settled heads, bounded
  task automatic gate(input logic g);
    for (int i = 0; i < 300 && g == 1'b0 && seek_settled_n !== 1'b0; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    write_enable_gate_n <= g;
  endtask : gate
  // Positive leg crossing above negative marks one reversal
  task automatic flux(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      write_flux_pos <= 1'b1;
      write_flux_neg <= 1'b0;
      repeat (2) @(posedge sys_clk);
      write_flux_pos <= 1'b0;
      write_flux_neg <= 1'b1;
      @(posedge sys_clk);
    end
  endtask : flux
  // Deselect for a few cycles, then select again
  task automatic resel();
    @(posedge sys_clk);
    drive_select_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    drive_select_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : resel
endmodule : dswi_ctrl_model
`default_nettype wire

//--- testbench/dswi_top_assertions.sv
// Port-level checks for the disc seek and write block
`timescale 1ns/1ns
`default_nettype none
module dswi_top_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic drive_select_n,
  input wire logic step_n,
  input wire logic [3:0] head_select_code_n,
  input wire logic write_enable_gate_n,
  input wire logic head_flux_in,
  input wire logic seek_settled_n,
  input wire logic ready_n,
  input wire logic revolution_marker_n,
  input wire logic write_unsafe_fault_n,
  input wire logic read_flux_pos,
  input wire logic read_flux_neg,
  input wire logic head_flux_out,
  input wire logic preamp_write_mode,
  input wire logic [3:0] head_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] quiet; // Cycles since the last step edge
  logic [7:0] low_len; // Cycles the marker has stayed low
  // Helper counters; quiet saturates so long idles never wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet <= 8'h00;
      low_len <= 8'h00;
    end else begin
      quiet <= $fell(step_n) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
      low_len <= revolution_marker_n ? 8'h00 : low_len + 8'h01;
    end
  end
  property p_settle_wait; $fell(seek_settled_n) |-> quiet >= 8'h32; endproperty
  a_settle_wait: assert property (p_settle_wait) else $error("settled too soon");
  property p_step_unsettle;
    $fell(step_n) && !drive_select_n && !ready_n && write_unsafe_fault_n |-> ##[1:3] seek_settled_n;
  endproperty
  a_step_unsettle: assert property (p_step_unsettle) else $error("step left settled");
  property p_mark_len; $rose(revolution_marker_n) |-> low_len == 8'h19; endproperty
  a_mark_len: assert property (p_mark_len) else $error("marker width wrong");
  property p_fault_hold; !write_unsafe_fault_n && !drive_select_n |=> !write_unsafe_fault_n; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped while selected");
  property p_read_pair; read_flux_neg == !read_flux_pos; endproperty
  a_read_pair: assert property (p_read_pair) else $error("read pair not opposite");
  property p_read_pulse; read_flux_pos |=> !read_flux_pos; endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read pulse too long");
  property p_read_edge;
    $rose(head_flux_in) && write_enable_gate_n && !preamp_write_mode |-> ##[1:3] read_flux_pos;
  endproperty
  a_read_edge: assert property (p_read_edge) else $error("reversal not reported");
  property p_gate_shut; write_enable_gate_n [*4] |-> $stable(head_flux_out); endproperty
  a_gate_shut: assert property (p_gate_shut) else $error("flux flipped while reading");
  property p_read_mode; write_enable_gate_n [*3] |-> !preamp_write_mode; endproperty
  a_read_mode: assert property (p_read_mode) else $error("preamp left in write");
  property p_head_map;
    (!drive_select_n && $stable(head_select_code_n)) [*3] |-> head_active == ~head_select_code_n;
  endproperty
  a_head_map: assert property (p_head_map) else $error("head decode wrong");
endmodule : dswi_top_assertions
bind dswi_top dswi_top_assertions dswi_top_assertions_inst (
  .sys_clk(sys_clk), .rst(rst), .drive_select_n(drive_select_n), .step_n(step_n),
  .head_select_code_n(head_select_code_n), .write_enable_gate_n(write_enable_gate_n),
  .head_flux_in(head_flux_in), .seek_settled_n(seek_settled_n), .ready_n(ready_n),
  .revolution_marker_n(revolution_marker_n), .write_unsafe_fault_n(write_unsafe_fault_n),
  .read_flux_pos(read_flux_pos), .read_flux_neg(read_flux_neg),
  .head_flux_out(head_flux_out), .preamp_write_mode(preamp_write_mode),
  .head_active(head_active)
);
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the disc seek and write block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dswi_pkg::*;
  localparam int unsigned REV = 200; // Short revolution for simulation
  localparam logic [31:0] PWR = 32'h0000_0001 << CTRL_PWR_OK; // Power good
  localparam logic [31:0] FLT = 32'h0000_0001 << EV_FAULT; // Fault event bit
  logic sys_clk = 1'b0; // 25 MHz clock
  logic rst = 1'b1; // Async reset
  logic drive_select_n, step_n, direction_n, write_enable_gate_n, write_flux_pos, write_flux_neg;
  logic [3:0] head_select_code_n, head_active;
  logic head_flux_in, spindle_tick = 1'b0, spin = 1'b1, last_hfo = 1'b0;
  logic seek_settled_n, at_outer_cylinder_n, ready_n, revolution_marker_n, irq;
  logic write_unsafe_fault_n, read_flux_pos, read_flux_neg, head_flux_out;
  logic preamp_write_mode, unsafe_sense_current;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int bad_count = 0, n_compared = 0, cyc = 0, n_wr = 0, n_rd = 0, tcnt = 0, n, t0;
  always #20 sys_clk = ~sys_clk;
  dswi_ctrl_model dswi_ctrl_model_inst (.*);
  dswi_top #(.REV_CYC(REV)) dswi_top_inst (.*);
  // Tallies and spindle sensor, one tick per revolution while spinning
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    last_hfo <= head_flux_out;
    if (head_flux_out !== last_hfo) n_wr <= n_wr + 1;
    if (read_flux_pos === 1'b1) n_rd <= n_rd + 1;
    tcnt <= (tcnt == REV - 1) ? 0 : tcnt + 1;
    spindle_tick <= spin && tcnt == 0;
  end
  // Verdict in one place
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // A wait that ran out is a mismatch and ends the run
  task automatic tmo(input int lim);
    if (n >= lim) begin
      bad_count++;
      $display("MISMATCH t=%0t wait ran out", $time);
      complete_run();
    end
  endtask : tmo
  // One AXI4-Lite access; payload held until each channel is taken
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
    rd = s_axi_rdata;
    rsp = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    tmo(40);
  endtask : acc
  // Wait for heads settled, bounded
  task automatic settle();
    for (n = 0; n < 400 && seek_settled_n !== 1'b0; n++) @(posedge sys_clk);
    tmo(400);
  endtask : settle
  // Main sequence
  initial begin
    {head_flux_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (300) @(posedge sys_clk);
    chk(ready_n, 1'b1);
    acc(1'b1, ADDR_CTRL, PWR);
    for (n = 0; n < 900 && ready_n !== 1'b0; n++) @(posedge sys_clk);
    tmo(900);
    settle();
    chk(at_outer_cylinder_n, 1'b0);
    $display("Test power-up done");
    repeat (3) dswi_ctrl_model_inst.step(DIR_IN_LEVEL, 0);
    chk(seek_settled_n, 1'b1);
    settle();
    acc(1'b0, ADDR_CYL, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    chk(at_outer_cylinder_n, 1'b1);
    repeat (3) dswi_ctrl_model_inst.step(~DIR_IN_LEVEL, 60);
    settle();
    acc(1'b0, ADDR_CYL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(at_outer_cylinder_n, 1'b0);
    $display("Test seek done");
    for (int h = 7; h >= 0; h -= 2) begin
      dswi_ctrl_model_inst.head(4'(h));
      repeat (4) @(posedge sys_clk);
      chk(32'(head_active), h);
    end
    dswi_ctrl_model_inst.head(4'h0);
    acc(1'b1, ADDR_IRQ_EN, FLT);
    acc(1'b0, ADDR_IRQ_EN, 32'h0000_0000);
    chk(rd, FLT);
    t0 = n_wr;
    dswi_ctrl_model_inst.gate(1'b0);
    dswi_ctrl_model_inst.flux(4);
    chk(preamp_write_mode, 1'b1);
    dswi_ctrl_model_inst.gate(1'b1);
    dswi_ctrl_model_inst.flux(2);
    repeat (4) @(posedge sys_clk);
    chk(n_wr - t0, 4);
    chk(preamp_write_mode, 1'b0);
    t0 = n_rd;
    repeat (3) begin
      @(posedge sys_clk) head_flux_in <= 1'b1;
      repeat (3) @(posedge sys_clk) head_flux_in <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    chk(n_rd - t0, 3);
    chk(write_unsafe_fault_n, 1'b1);
    $display("Test write and read done");
    acc(1'b1, ADDR_CTRL, PWR | (32'h0000_0001 << CTRL_WPROT));
    dswi_ctrl_model_inst.gate(1'b0);
    repeat (4) @(posedge sys_clk);
    chk(write_unsafe_fault_n, 1'b0);
    chk(irq, 1'b1);
    dswi_ctrl_model_inst.gate(1'b1);
    dswi_ctrl_model_inst.step(DIR_IN_LEVEL, 60);
    acc(1'b0, ADDR_CYL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    acc(1'b1, ADDR_IRQ_EN, 32'h0000_0000);
    chk(irq, 1'b0);
    acc(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    chk(rd & FLT, FLT);
    acc(1'b1, ADDR_IRQ_EN, FLT);
    acc(1'b1, ADDR_IRQ_CLR, FLT);
    chk(irq, 1'b0);
    acc(1'b1, ADDR_CTRL, PWR);
    dswi_ctrl_model_inst.resel();
    chk(write_unsafe_fault_n, 1'b1);
    acc(1'b1, ADDR_CTRL, PWR | (32'h0000_0001 << CTRL_OFF_TRACK));
    dswi_ctrl_model_inst.gate(1'b0);
    repeat (4) @(posedge sys_clk);
    chk(write_unsafe_fault_n, 1'b0);
    dswi_ctrl_model_inst.gate(1'b1);
    dswi_ctrl_model_inst.resel();
    chk(write_unsafe_fault_n, 1'b0);
    acc(1'b1, ADDR_CTRL, PWR);
    dswi_ctrl_model_inst.resel();
    chk(write_unsafe_fault_n, 1'b1);
    acc(1'b0, 8'h20, 32'h0000_0000);
    chk(rsp, RESP_SLVERR);
    $display("Test faults done");
    dswi_ctrl_model_inst.gate(1'b0);
    for (n = 0; n < 400 && unsafe_sense_current !== 1'b1; n++) @(posedge sys_clk);
    tmo(400);
    repeat (4) @(posedge sys_clk);
    chk(write_unsafe_fault_n, 1'b0);
    dswi_ctrl_model_inst.gate(1'b1);
    dswi_ctrl_model_inst.resel();
    chk(write_unsafe_fault_n, 1'b1);
    // High, low, high, low: both timestamps fall on a falling edge of the marker
    for (int k = 0; k < 4; k++) begin
      for (n = 0; n < 400 && revolution_marker_n !== !k[0]; n++) @(posedge sys_clk);
      tmo(400);
      if (k == 1) t0 = cyc;
    end
    chk(32'(cyc - t0), REV);
    $display("Test unsafe and marker done");
    spin <= 1'b0;
    for (n = 0; n < 600 && ready_n !== 1'b1; n++) @(posedge sys_clk);
    tmo(600);
    spin <= 1'b1;
    repeat (500) @(posedge sys_clk);
    chk(ready_n, 1'b1);
    $display("Test speed loss done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
